// file: design/brc_cfg.svh
// Offsets, field positions, reset values and cycle counts of the bridge reset block
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH

`define BRC_CTRL_OFS 8'h00
`define BRC_PWR_OFS 8'h04
`define BRC_MASK_OFS 8'h08
`define BRC_STAT_OFS 8'h0C

`define BRC_CTRL_SECRST_BIT 0
`define BRC_CTRL_CHIPRST_BIT 1
`define BRC_CTRL_HALF_BIT 2

`define BRC_STAT_SECRST_BIT 0
`define BRC_STAT_CHIPBUSY_BIT 1
`define BRC_STAT_WIDE_BIT 2
`define BRC_STAT_READY_BIT 3
`define BRC_STAT_LOADED_BIT 4
`define BRC_STAT_FBSEEN_BIT 5
`define BRC_STAT_STOPPED_BIT 6

`define BRC_SECRST_RST 1'b0
`define BRC_HALF_RST 1'b1
`define BRC_MASK_RST 10'h000
`define BRC_PWR_D0 2'h0
`define BRC_PWR_D1 2'h1
`define BRC_PWR_D2 2'h2
`define BRC_PWR_D3HOT 2'h3

`define BRC_RESP_OKAY 2'h0
`define BRC_RESP_SLVERR 2'h2
`define BRC_RESP_DECERR 2'h3

`define BRC_HOLDOFF_CYCLES 5'd16
`define BRC_TAIL_CYCLES 5'd20
`define BRC_PURGE_CYCLES 5'd4
`define BRC_LOAD_LAST 5'd22
`define BRC_LOAD_FIRST_SAMPLE 5'd3
`define BRC_LOAD_LAST_SAMPLE 5'd18

`endif

// file: design/brc_pkg.sv
// Types shared by the bridge reset, power and clock control block
package brc_pkg;
    typedef enum logic [1:0] {cr_idle, cr_purge, cr_hold, cr_tail} brc_chip_state_t;
    typedef enum logic [1:0] {ld_idle, ld_run, ld_done} brc_load_state_t;
endpackage : brc_pkg

// file: design/brc_sync.sv
// Two-flop synchroniser for a group of pin inputs
module brc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clock_i,           // Block clock
    input wire logic nrst_i,            // Synchronous reset, active low
    input wire logic [W-1:0] async_i,   // Pins from outside the clock domain
    output logic [W-1:0] sync_o         // Synchronised levels
);
    logic [W-1:0] meta;

    // First stage is read by the second stage only
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            meta <= RST;
            sync_o <= RST;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule : brc_sync

// file: design/brc_mask_load.sv
// Serial clock-mask loader run once after primary reset release
module brc_mask_load (
    input wire logic clock_i,           // Block clock
    input wire logic nrst_i,            // Synchronous reset, active low
    input wire logic clear_i,           // Primary reset active, rearms loader
    input wire logic start_i,           // Begin loading
    input wire logic serial_i,          // Synchronised serial mask data
    output logic shift_mode_o,          // 0 load, 1 shift for external register
    output logic shift_win_o,           // Shift clock window for external register
    output logic gpio_oe_n_o,           // Low while loader drives the control pins
    output logic done_o,                // Mask load finished
    output logic mask_valid_o,          // One-cycle pulse with new mask
    output logic [9:0] mask_o           // Clock disable mask, 1 stops a clock
);
    import brc_pkg::*;
    `include "brc_cfg.svh"

    brc_load_state_t state;
    logic [4:0] cnt;
    logic [15:0] shreg;

    always_ff @(posedge clock_i) begin
        if (!nrst_i || clear_i) begin
            state <= ld_idle;
            cnt <= 5'd0;
        end else begin
            unique case (state)
                ld_idle: begin
                    if (start_i) begin
                        state <= ld_run;
                        cnt <= 5'd0;
                    end
                end
                ld_run: begin
                    if (cnt == `BRC_LOAD_LAST) begin
                        state <= ld_done;
                    end else begin
                        cnt <= cnt + 5'd1;
                    end
                end
                ld_done: begin
                end
                default: begin
                    state <= ld_idle;
                end
            endcase
        end
    end

    // Most significant bit arrives first; two cycles of pin sync latency
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            shreg <= 16'h0000;
        end else if (state == ld_run && cnt >= `BRC_LOAD_FIRST_SAMPLE
                     && cnt <= `BRC_LOAD_LAST_SAMPLE) begin
            shreg <= {shreg[14:0], serial_i};
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || clear_i) begin
            shift_mode_o <= 1'b1;
            shift_win_o <= 1'b0;
            gpio_oe_n_o <= 1'b1;
        end else begin
            shift_mode_o <= !(state == ld_idle && start_i);
            shift_win_o <= (state == ld_run && cnt < 5'd16) || (state == ld_idle && start_i);
            gpio_oe_n_o <= !((state == ld_idle && start_i) ||
                             (state == ld_run && cnt != `BRC_LOAD_LAST));
        end
    end

    // Slot clock runs if either presence bit is low; device bits are direct disables
    always_ff @(posedge clock_i) begin
        if (!nrst_i || clear_i) begin
            done_o <= 1'b0;
            mask_valid_o <= 1'b0;
            mask_o <= `BRC_MASK_RST;
        end else begin
            mask_valid_o <= 1'b0;
            if (state == ld_run && cnt == `BRC_LOAD_LAST) begin
                done_o <= 1'b1;
                mask_valid_o <= 1'b1;
                mask_o <= {shreg[13:8], &shreg[7:6], &shreg[5:4], &shreg[3:2], &shreg[1:0]};
            end
        end
    end
endmodule : brc_mask_load

// file: design/brc_reset_power_ctl.sv
// Reset, power-state and secondary clock control for a two-port bus bridge
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
module brc_reset_power_ctl (
    input wire logic clock_i,                       // Primary clock, 20 MHz
    input wire logic nrst_i,                        // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr_i,          // Write address
    input wire logic s_axi_awvalid_i,               // Write address valid
    output logic s_axi_awready_o,                   // Write address ready
    input wire logic [31:0] s_axi_wdata_i,          // Write data
    input wire logic [3:0] s_axi_wstrb_i,           // Write byte strobes
    input wire logic s_axi_wvalid_i,                // Write data valid
    output logic s_axi_wready_o,                    // Write data ready
    output logic [1:0] s_axi_bresp_o,               // Write response
    output logic s_axi_bvalid_o,                    // Write response valid
    input wire logic s_axi_bready_i,                // Write response ready
    input wire logic [7:0] s_axi_araddr_i,          // Read address
    input wire logic s_axi_arvalid_i,               // Read address valid
    output logic s_axi_arready_o,                   // Read address ready
    output logic [31:0] s_axi_rdata_o,              // Read data
    output logic [1:0] s_axi_rresp_o,               // Read response
    output logic s_axi_rvalid_o,                    // Read data valid
    input wire logic s_axi_rready_i,                // Read data ready
    input wire logic primary_rst_n_i,               // Primary reset pin, active low
    input wire logic primary_wide_req_n_i,          // Primary wide request pin
    input wire logic clock_stop_strap_i,            // Strap, low allows clock stop in D3hot
    input wire logic secondary_clk_feedback_i,      // Looped-back secondary clock
    input wire logic clock_mask_serial_in_i,        // Serial clock mask data
    output logic [9:0] secondary_clk_out_o,         // Secondary clock outputs
    output logic secondary_rst_n_o,                 // Secondary bus reset, active low
    output logic mask_shift_mode_o,                 // Mask register control, 0 load
    output logic mask_shift_win_o,                  // Mask register shift window
    output logic mask_gpio_oe_n_o,                  // Low while mask pins are driven
    output logic primary_bus_oe_n_o,                // High floats all primary signals
    output logic secondary_ctl_oe_n_o,              // High floats secondary control, grants
    output logic secondary_drive_oe_n_o,            // Low drives the reset levels below
    output logic [31:0] secondary_ad_o,             // Secondary address/data reset level
    output logic [3:0] secondary_cmd_byte_en_o,     // Secondary command/byte enable level
    output logic secondary_parity_o,                // Secondary parity reset level
    output logic secondary_wide_req_n_o,            // Secondary wide request level
    output logic buffer_flush_o,                    // Clear transaction buffers
    output logic sec_bus_b2_o,                      // Secondary bus in B2
    output logic wide_primary_en_o,                 // Primary wide extension enabled
    output logic access_ready_o                     // Configuration access allowed
);
    import brc_pkg::*;
    `include "brc_cfg.svh"

    logic [4:0] pins_s;
    logic prst_act;
    logic wide_req_s;
    logic strap_s;
    logic fb_s;
    logic mask_ser_s;
    logic [4:0] hold_cnt;
    logic holdoff_done;
    brc_chip_state_t cr_state;
    logic [4:0] cr_cnt;
    logic chip_origin;
    logic sec_bit;
    logic half_rate;
    logic [9:0] clk_mask;
    logic [1:0] pwr_state;
    logic fb_prev;
    logic fb_seen;
    logic phase;
    logic ld_done;
    logic ld_valid;
    logic [9:0] ld_mask;
    logic regs_rst;
    logic access_ok;
    logic clk_stop;
    logic next_sec_assert;
    logic wr_en;
    logic wr_ok;
    logic [7:0] wr_addr;
    logic wr_ctrl;
    logic wr_pwr;
    logic wr_mask;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] stat_word;

    // Pins are asynchronous; primary reset resets to asserted
    brc_sync #(
        .W(5),
        .RST(5'h1E)
    ) u_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .async_i({clock_mask_serial_in_i, secondary_clk_feedback_i, clock_stop_strap_i,
                  primary_wide_req_n_i, primary_rst_n_i}),
        .sync_o(pins_s)
    );

    assign prst_act = !pins_s[0] || !nrst_i;
    assign wide_req_s = pins_s[1];
    assign strap_s = pins_s[2];
    assign fb_s = pins_s[3];
    assign mask_ser_s = pins_s[4];

    brc_mask_load u_load (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .clear_i(prst_act),
        .start_i(!prst_act && !ld_done),
        .serial_i(mask_ser_s),
        .shift_mode_o(mask_shift_mode_o),
        .shift_win_o(mask_shift_win_o),
        .gpio_oe_n_o(mask_gpio_oe_n_o),
        .done_o(ld_done),
        .mask_valid_o(ld_valid),
        .mask_o(ld_mask)
    );

    // Holdoff counts from the synchronised release, so the first window is whole
    always_ff @(posedge clock_i) begin
        if (prst_act) begin
            hold_cnt <= 5'd0;
        end else if (hold_cnt != `BRC_HOLDOFF_CYCLES) begin
            hold_cnt <= hold_cnt + 5'd1;
        end
    end

    assign holdoff_done = (hold_cnt == `BRC_HOLDOFF_CYCLES);
    assign access_ok = holdoff_done && cr_state != cr_purge && cr_state != cr_tail;
    assign regs_rst = prst_act || cr_state == cr_purge;
    assign clk_stop = (pwr_state == `BRC_PWR_D3HOT) && !strap_s;

    // Write channel: address and data are taken together, one write at a time
    assign wr_en = s_axi_awvalid_i && s_axi_awready_o;
    assign wr_addr = {s_axi_awaddr_i[7:2], 2'h0};
    assign wr_ok = wr_en && access_ok;
    assign wr_ctrl = wr_ok && wr_addr == `BRC_CTRL_OFS && s_axi_wstrb_i[0];
    assign wr_pwr = wr_ok && wr_addr == `BRC_PWR_OFS && s_axi_wstrb_i[0];
    assign wr_mask = wr_ok && wr_addr == `BRC_MASK_OFS;
    assign rd_en = s_axi_arvalid_i && s_axi_arready_o;
    assign rd_addr = {s_axi_araddr_i[7:2], 2'h0};

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end else begin
            s_axi_awready_o <= s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o
                               && !s_axi_bvalid_o;
            s_axi_wready_o <= s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o
                              && !s_axi_bvalid_o;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `BRC_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid_o <= 1'b1;
            if (!access_ok) begin
                s_axi_bresp_o <= `BRC_RESP_SLVERR;
            end else if (wr_addr > `BRC_STAT_OFS) begin
                s_axi_bresp_o <= `BRC_RESP_DECERR;
            end else begin
                s_axi_bresp_o <= `BRC_RESP_OKAY;
            end
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Chip reset sequence: purge, wait for secondary bit clear, tail, self-clear
    always_ff @(posedge clock_i) begin
        if (prst_act) begin
            cr_state <= cr_idle;
            cr_cnt <= 5'd0;
            chip_origin <= 1'b0;
        end else begin
            unique case (cr_state)
                cr_idle: begin
                    cr_cnt <= 5'd0;
                    if (wr_ctrl && s_axi_wdata_i[`BRC_CTRL_CHIPRST_BIT]) begin
                        cr_state <= cr_purge;
                        chip_origin <= 1'b1;
                    end else if (wr_pwr && pwr_state == `BRC_PWR_D3HOT
                                 && s_axi_wdata_i[1:0] == `BRC_PWR_D0) begin
                        cr_state <= cr_purge;
                        chip_origin <= 1'b0;
                    end
                end
                cr_purge: begin
                    if (cr_cnt == `BRC_PURGE_CYCLES - 5'd1) begin
                        cr_cnt <= 5'd0;
                        cr_state <= chip_origin ? cr_hold : cr_idle;
                    end else begin
                        cr_cnt <= cr_cnt + 5'd1;
                    end
                end
                cr_hold: begin
                    if (!sec_bit) begin
                        cr_state <= cr_tail;
                    end
                end
                cr_tail: begin
                    if (cr_cnt == `BRC_TAIL_CYCLES - 5'd1) begin
                        cr_state <= cr_idle;
                        chip_origin <= 1'b0;
                    end else begin
                        cr_cnt <= cr_cnt + 5'd1;
                    end
                end
            endcase
        end
    end

    // Control register; secondary bit is forced on through a chip-bit purge
    always_ff @(posedge clock_i) begin
        if (regs_rst) begin
            sec_bit <= (cr_state == cr_purge) && chip_origin;
            half_rate <= `BRC_HALF_RST;
        end else if (wr_ctrl) begin
            sec_bit <= s_axi_wdata_i[`BRC_CTRL_SECRST_BIT];
            half_rate <= s_axi_wdata_i[`BRC_CTRL_HALF_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (regs_rst) begin
            pwr_state <= `BRC_PWR_D0;
        end else if (wr_pwr && pwr_state == `BRC_PWR_D0
                     && s_axi_wdata_i[1:0] == `BRC_PWR_D3HOT) begin
            pwr_state <= `BRC_PWR_D3HOT;
        end
    end

    always_ff @(posedge clock_i) begin
        if (regs_rst) begin
            clk_mask <= `BRC_MASK_RST;
        end else if (ld_valid) begin
            clk_mask <= ld_mask;
        end else if (wr_mask) begin
            if (s_axi_wstrb_i[0]) begin
                clk_mask[7:0] <= s_axi_wdata_i[7:0];
            end
            if (s_axi_wstrb_i[1]) begin
                clk_mask[9:8] <= s_axi_wdata_i[9:8];
            end
        end
    end

    // Feedback activity shows the loop-back is wired
    always_ff @(posedge clock_i) begin
        if (regs_rst) begin
            // Track the pin through reset so release shows no false edge
            fb_prev <= fb_s;
            fb_seen <= 1'b0;
        end else begin
            fb_prev <= fb_s;
            if (fb_s != fb_prev) begin
                fb_seen <= 1'b1;
            end
        end
    end

    // Wide mode latched continuously while primary reset is held
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            wide_primary_en_o <= 1'b0;
        end else if (!pins_s[0]) begin
            wide_primary_en_o <= !wide_req_s;
        end
    end

    // Half rate toggles a flop; full rate passes the run level to an external gate
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            phase <= 1'b0;
        end else begin
            phase <= !phase;
        end
    end

    for (genvar i = 0; i < 10; i++) begin : g_clk
        always_ff @(posedge clock_i) begin
            if (!nrst_i) begin
                secondary_clk_out_o[i] <= 1'b0;
            end else begin
                secondary_clk_out_o[i] <= !clk_mask[i] && !clk_stop
                                          && (half_rate ? phase : 1'b1);
            end
        end
    end

    assign next_sec_assert = prst_act || sec_bit || !ld_done
                             || (cr_state == cr_purge && chip_origin);

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            secondary_rst_n_o <= 1'b0;
            primary_bus_oe_n_o <= 1'b1;
            secondary_ctl_oe_n_o <= 1'b1;
            secondary_drive_oe_n_o <= 1'b0;
            buffer_flush_o <= 1'b1;
            sec_bus_b2_o <= 1'b0;
            access_ready_o <= 1'b0;
        end else begin
            secondary_rst_n_o <= !next_sec_assert;
            primary_bus_oe_n_o <= prst_act || cr_state == cr_purge;
            secondary_ctl_oe_n_o <= next_sec_assert || cr_state == cr_purge;
            secondary_drive_oe_n_o <= !next_sec_assert;
            buffer_flush_o <= next_sec_assert || cr_state == cr_purge;
            sec_bus_b2_o <= (pwr_state == `BRC_PWR_D3HOT);
            access_ready_o <= access_ok;
        end
    end

    // Reset levels on the secondary data lines are constant low
    always_ff @(posedge clock_i) begin
        secondary_ad_o <= 32'h0000_0000;
        secondary_cmd_byte_en_o <= 4'h0;
        secondary_parity_o <= 1'b0;
        secondary_wide_req_n_o <= 1'b0;
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`BRC_STAT_SECRST_BIT] = !secondary_rst_n_o;
        stat_word[`BRC_STAT_CHIPBUSY_BIT] = (cr_state != cr_idle);
        stat_word[`BRC_STAT_WIDE_BIT] = wide_primary_en_o;
        stat_word[`BRC_STAT_READY_BIT] = access_ok;
        stat_word[`BRC_STAT_LOADED_BIT] = ld_done;
        stat_word[`BRC_STAT_FBSEEN_BIT] = fb_seen;
        stat_word[`BRC_STAT_STOPPED_BIT] = clk_stop;
    end

    // Read channel: address taken, data one cycle later
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_axi_arready_o <= 1'b0;
        end else begin
            s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `BRC_RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= `BRC_RESP_OKAY;
            s_axi_rdata_o <= 32'h0000_0000;
            if (!access_ok) begin
                s_axi_rresp_o <= `BRC_RESP_SLVERR;
            end else begin
                unique case (rd_addr)
                    `BRC_CTRL_OFS: s_axi_rdata_o <= {29'h0, half_rate,
                                                     cr_state != cr_idle, sec_bit};
                    `BRC_PWR_OFS: s_axi_rdata_o <= {30'h0, pwr_state};
                    `BRC_MASK_OFS: s_axi_rdata_o <= {22'h0, clk_mask};
                    `BRC_STAT_OFS: s_axi_rdata_o <= stat_word;
                    default: s_axi_rresp_o <= `BRC_RESP_DECERR;
                endcase
            end
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule : brc_reset_power_ctl

// file: verification/brc_props.sv
// Port assertions for the bridge reset block
module brc_props (
    input wire logic clock_i, // Clock
    input wire logic nrst_i, // Reset
    input wire logic primary_rst_n_i, // Pin
    input wire logic clock_stop_strap_i, // Strap
    input wire logic secondary_rst_n_o, // Sec reset
    input wire logic access_ready_o, // Ready
    input wire logic primary_bus_oe_n_o, // Float
    input wire logic secondary_ctl_oe_n_o, // Float
    input wire logic secondary_drive_oe_n_o, // Drive
    input wire logic buffer_flush_o, // Flush
    input wire logic sec_bus_b2_o, // B2
    input wire logic [9:0] secondary_clk_out_o // Clocks
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // Four cycles of pin low cover the two-flop sync plus output flop
    property p_prst; !primary_rst_n_i [*4] |-> !secondary_rst_n_o; endproperty
    a_prst: assert property (p_prst) else $error("no sec reset");
    // Holdoff counter adds one flop, so five cycles of pin low
    property p_shut; !primary_rst_n_i [*5] |-> !access_ready_o; endproperty
    a_shut: assert property (p_shut) else $error("open in reset");
    property p_hold; $rose(access_ready_o) |-> $past(primary_rst_n_i, 16); endproperty
    a_hold: assert property (p_hold) else $error("early ready");
    property p_pflt; !primary_rst_n_i [*4] |-> primary_bus_oe_n_o && !secondary_drive_oe_n_o; endproperty
    a_pflt: assert property (p_pflt) else $error("bad float");
    property p_sflt; !secondary_rst_n_o [*2] |-> secondary_ctl_oe_n_o && !secondary_drive_oe_n_o; endproperty
    a_sflt: assert property (p_sflt) else $error("bad sec float");
    property p_flush; $fell(secondary_rst_n_o) |-> ##[0:2] buffer_flush_o; endproperty
    a_flush: assert property (p_flush) else $error("no flush");
    property p_load; $rose(secondary_rst_n_o) |-> $past(primary_rst_n_i, 23); endproperty
    a_load: assert property (p_load) else $error("early release");
    property p_stop; (sec_bus_b2_o && !clock_stop_strap_i) [*4] |-> secondary_clk_out_o == 10'h000; endproperty
    a_stop: assert property (p_stop) else $error("clocks run");
    c_rel: cover property ($rose(secondary_rst_n_o));
    c_b2: cover property ($rose(sec_bus_b2_o));
    c_rdy: cover property ($rose(access_ready_o));
endmodule : brc_props
bind brc_reset_power_ctl brc_props u_brc_props (.*);

// file: verification/brc_far_side.sv
// External clock-mask shift register and clock loop-back
module brc_far_side #(
    parameter logic [15:0] PATTERN = 16'h1F00
) (
    input wire logic clock_i, // Clock
    input wire logic mode_i, // 0 load, 1 shift
    input wire logic win_i, // Shift window
    input wire logic oe_n_i, // Low while pins driven
    input wire logic [9:0] clk_i, // Secondary clocks
    output logic serial_o, // Serial mask, MSB first
    output logic fb_o // Looped-back clock
);
    logic [15:0] sr = 16'h0000;
    // Undriven control pins freeze the register, as a real part would
    always_ff @(posedge clock_i) begin
        if (!oe_n_i && win_i) sr <= mode_i ? {sr[14:0], 1'b0} : PATTERN;
    end
    assign serial_o = sr[15];
    assign fb_o = clk_i[9];
endmodule : brc_far_side

// file: verification/tb.sv
// Register-level bench for the bridge reset block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
    logic s_axi_rready_i, primary_rst_n_i, primary_wide_req_n_i, clock_stop_strap_i;
    logic secondary_clk_feedback_i, clock_mask_serial_in_i, s_axi_awready_o, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, secondary_rst_n_o, mask_shift_mode_o;
    logic mask_shift_win_o, mask_gpio_oe_n_o, primary_bus_oe_n_o, secondary_ctl_oe_n_o;
    logic secondary_drive_oe_n_o, secondary_parity_o, secondary_wide_req_n_o, buffer_flush_o;
    logic sec_bus_b2_o, wide_primary_en_o, access_ready_o;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, secondary_ad_o, rd;
    logic [3:0] s_axi_wstrb_i, secondary_cmd_byte_en_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
    logic [9:0] secondary_clk_out_o;
    int n_fail = 0;
    int check_count = 0;
    brc_reset_power_ctl u_brc_reset_power_ctl (.*);
    brc_far_side u_brc_far_side (.clock_i(clock_i), .mode_i(mask_shift_mode_o),
        .win_i(mask_shift_win_o), .oe_n_i(mask_gpio_oe_n_o), .clk_i(secondary_clk_out_o),
        .serial_o(clock_mask_serial_in_i), .fb_o(secondary_clk_feedback_i));
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkr(input logic [1:0] exp);
        chk({30'h0, rs}, {30'h0, exp});
    endtask : chkr
    task automatic wt(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(posedge clock_i);
        if (s !== v) begin
            n_fail++;
            wrap_up();
        end
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        wt(s_axi_awready_o, 1'b1, 99);
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        wt(s_axi_bvalid_o, 1'b1, 99);
        rs = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        wt(s_axi_arready_o, 1'b1, 99);
        s_axi_arvalid_i <= 1'b0;
        wt(s_axi_rvalid_o, 1'b1, 99);
        rd = s_axi_rdata_o;
        rs = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge clock_i);
    endtask : rdr
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        {nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 5'h00;
        {s_axi_rready_i, primary_rst_n_i, primary_wide_req_n_i, clock_stop_strap_i} = 4'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
        s_axi_wstrb_i = 4'hF;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rdr(8'h0C);
        chkr(2'h2);
        primary_rst_n_i <= 1'b1;
        wt(access_ready_o, 1'b1, 40);
        chk({31'h0, wide_primary_en_o}, 32'h1);
        wt(secondary_rst_n_o, 1'b1, 40);
        rdr(8'h08);
        chk(rd, 32'h1F0);
        rdr(8'h0C);
        chk(rd, 32'h3C);
        for (int k = 1; k < 3; k++) begin
            wr(8'h04, 32'(k));
            rdr(8'h04);
            chk(rd, 32'h0);
        end
        wr(8'h00, 32'h0);
        chk({22'h0, secondary_clk_out_o}, 32'h20F);
        wr(8'h04, 32'h3);
        chk({31'h0, sec_bus_b2_o}, 32'h1);
        chk({22'h0, secondary_clk_out_o}, 32'h0);
        rdr(8'h0C);
        chk(rd & 32'h40, 32'h40);
        wr(8'h04, 32'h0);
        // Wake purge lasts four cycles
        repeat (8) @(posedge clock_i);
        wt(access_ready_o, 1'b1, 40);
        rdr(8'h00);
        chk(rd, 32'h4);
        chk({31'h0, secondary_rst_n_o}, 32'h1);
        wr(8'h00, 32'h5);
        wt(secondary_rst_n_o, 1'b0, 8);
        chk(secondary_ad_o, 32'h0);
        chk({26'h0, secondary_cmd_byte_en_o, secondary_parity_o, secondary_wide_req_n_o}, 32'h0);
        chk({28'h0, secondary_ctl_oe_n_o, secondary_drive_oe_n_o, buffer_flush_o, primary_bus_oe_n_o}, 32'hA);
        rdr(8'h0C);
        chkr(2'h0);
        wr(8'h00, 32'h4);
        wt(secondary_rst_n_o, 1'b1, 8);
        wr(8'h00, 32'h6);
        repeat (8) @(posedge clock_i);
        rdr(8'h00);
        chk(rd, 32'h7);
        chk({31'h0, secondary_rst_n_o}, 32'h0);
        wr(8'h00, 32'h4);
        rdr(8'h0C);
        chkr(2'h2);
        wt(access_ready_o, 1'b1, 20);
        rdr(8'h00);
        chk(rd, 32'h4);
        rdr(8'h10);
        chkr(2'h3);
        wrap_up();
    end
endmodule : tb
